// ---- inc/sas_params.svh ----
/*
  Constants for the converter sequencer: field codes, timing counts, reset values.
  Assumes inclusion by bare name from design files.
*/
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

`define SAS_DIV_SEL_16 2'b00
`define SAS_DIV_SEL_8 2'b01
`define SAS_DIV_SEL_1 2'b10
`define SAS_DIV_SEL_2 2'b11
`define SAS_CHAN_LAST_PIN_A 4'h4
`define SAS_CHAN_LAST_PIN_B 4'hB
`define SAS_CHAN_QUARTER 4'hC
`define SAS_CHAN_BANDGAP 4'hD
`define SAS_SOURCE_NONE 4'hF
`define SAS_EXTRA_PERIODS 5'h02
`define SAS_RESULT_RESET 12'h000
`define SAS_BIAS_TIME_US 256
`define SAS_CLOCK_MHZ 125
`define SAS_BIAS_CYCLES (`SAS_BIAS_TIME_US * `SAS_CLOCK_MHZ)

`endif

// ---- inc/sas_pkg.sv ----
/*
  Types for the converter sequencer.
  Assumes the params header supplies the numbers.
*/
package sas_pkg;

  typedef struct packed {
    logic [1:0] conv_clock_divider_sel;
    logic [1:0] sample_width_sel;
    logic [1:0] resolution_sel;
    logic global_channel_gate;
    logic [3:0] channel_select_field;
  } sas_config_t;

  typedef struct packed {
    logic analog_sel_valid;
    logic [3:0] analog_source;
    logic sample_pulse_width;
    logic bit_strobe;
    logic [3:0] bit_index;
  } sas_analog_t;

  typedef enum logic [1:0] {
    SAS_IDLE = 2'b00,
    SAS_SAMPLE = 2'b01,
    SAS_CONVERT = 2'b10,
    SAS_FINISH = 2'b11
  } sas_state_t;

endpackage

// ---- src/sas_channel_mux.sv ----
/*
  Channel decode: gate and four-bit field to an analog source code and pin strobes.
  Assumes the analog multiplexer honours analog_sel_valid.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sas_params.svh"

module sas_channel_mux (
  input wire logic global_channel_gate,
  input wire logic [3:0] channel_select_field,
  output logic source_valid,
  output logic [3:0] analog_source,
  output logic [4:0] porta_select,
  output logic [7:1] portb_select
);

  logic is_pin_a;
  logic is_pin_b;
  logic is_internal;

  // Codes 111x select nothing, gate low selects nothing
  assign is_pin_a = channel_select_field <= `SAS_CHAN_LAST_PIN_A;
  assign is_pin_b = !is_pin_a && channel_select_field <= `SAS_CHAN_LAST_PIN_B;
  assign is_internal = channel_select_field == `SAS_CHAN_QUARTER ||
                       channel_select_field == `SAS_CHAN_BANDGAP;
  assign source_valid = global_channel_gate && (is_pin_a || is_pin_b || is_internal);
  assign analog_source = source_valid ? channel_select_field : `SAS_SOURCE_NONE;
  assign porta_select = (source_valid && is_pin_a) ?
                        5'(5'h01 << channel_select_field[2:0]) : 5'h00;
  // Code 0101 is port B pin 1, so pin index is code minus 4
  assign portb_select = (source_valid && is_pin_b) ?
                        7'(8'(8'h01 << (channel_select_field - 4'h4)) >> 1) : 7'h00;

endmodule
`default_nettype wire

// ---- src/sas_clock_divider.sv ----
/*
  Conversion clock tick generator: one-cycle tick every 1, 2, 8 or 16 CPU cycles.
  Assumes a single CPU clock domain; restart realigns the phase.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sas_params.svh"

module sas_clock_divider (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic restart,
  input wire logic [1:0] conv_clock_divider_sel,
  output logic conversion_clock_tick
);

  logic [3:0] count;
  logic [3:0] terminal;

  // Divide codes follow the printed row order
  assign terminal = (conv_clock_divider_sel == `SAS_DIV_SEL_16) ? 4'hF :
                    (conv_clock_divider_sel == `SAS_DIV_SEL_8) ? 4'h7 :
                    (conv_clock_divider_sel == `SAS_DIV_SEL_2) ? 4'h1 : 4'h0;

  assign conversion_clock_tick = clock_enable && !restart && (count == terminal);

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      count <= 4'h0;
    else if (clock_enable)
    begin
      if (restart || count == terminal)
        count <= 4'h0;
      else
        count <= count + 4'h1;
    end
  end

endmodule
`default_nettype wire

// ---- src/sas_sequencer.sv ----
/*
  Converter sequencer: channel gate, pin analog config, conversion clock,
  sample pulse, SAR bit steps, done flag and end-of-conversion interrupt flag.
  Assumes software-facing bits arrive as plain synchronous ports and the
  comparator answers each bit strobe with compare_high in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sas_params.svh"

module sas_sequencer (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire sas_pkg::sas_config_t config_bits,
  input wire logic converter_enable,
  input wire logic start,
  input wire logic conv_irq_enable,
  input wire logic global_irq_enable,
  input wire logic irq_flag_write_zero,
  input wire logic [4:0] porta_analog_pin_bit,
  input wire logic [7:0] portb_analog_pin_bit,
  input wire logic compare_high,
  output sas_pkg::sas_analog_t analog_ctrl,
  output logic [4:0] porta_analog_select,
  output logic [7:1] portb_analog_select,
  output logic [4:0] porta_digital_enable,
  output logic [7:0] portb_digital_enable,
  output logic busy,
  output logic done,
  output logic [11:0] result,
  output logic conv_irq_flag_read,
  output logic conv_irq_request
);

  // ==========================================================
  // Decode helpers
  // ==========================================================
  function automatic logic [3:0] sample_periods(input logic [1:0] sel);
    sample_periods = 4'(4'h1 << sel);
  endfunction

  function automatic logic [3:0] resolution_bits(input logic [1:0] sel);
    if (sel[1])
      resolution_bits = 4'd12;
    else if (sel[0])
      resolution_bits = 4'd10;
    else
      resolution_bits = 4'd8;
  endfunction

  // Codes 111x and a closed gate leave nothing to convert
  function automatic logic source_valid_now(input logic gate, input logic [3:0] code);
    source_valid_now = gate && (code < 4'hE);
  endfunction

  sas_pkg::sas_state_t state;
  sas_pkg::sas_state_t next_state;
  sas_pkg::sas_config_t held;
  logic tick;
  logic restart;
  logic source_valid;
  logic [3:0] source_code;
  logic [4:0] porta_sel;
  logic [7:1] portb_sel;
  logic [3:0] period_count;
  logic [3:0] bit_index;
  logic [3:0] bits_total;
  logic [1:0] tail_count;
  logic [11:0] sar;
  logic done_prev;
  logic irq_flag;
  logic done_rise;
  logic start_ok;
  logic sample_end;
  logic convert_end;
  logic tail_end;

  // ==========================================================
  // Channel and pin configuration
  // ==========================================================
  sas_channel_mux u_mux (
    .global_channel_gate(held.global_channel_gate),
    .channel_select_field(held.channel_select_field),
    .source_valid(source_valid),
    .analog_source(source_code),
    .porta_select(porta_sel),
    .portb_select(portb_sel)
  );

  // Analog pins lose their digital buffer to stop leakage
  assign porta_digital_enable = ~porta_analog_pin_bit;
  assign portb_digital_enable = ~portb_analog_pin_bit;
  // The switch only closes during a conversion with a valid source
  assign porta_analog_select = busy ? porta_sel : 5'h00;
  assign portb_analog_select = busy ? portb_sel : 7'h00;

  // ==========================================================
  // Conversion clock
  // ==========================================================
  // Holding the divider at zero while idle starts the first period at the take
  assign restart = state == sas_pkg::SAS_IDLE;

  sas_clock_divider u_div (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .restart(restart),
    .conv_clock_divider_sel(held.conv_clock_divider_sel),
    .conversion_clock_tick(tick)
  );

  // ==========================================================
  // Sequence control
  // ==========================================================
  // Gate low: start is ignored and nothing converts
  // Live settings are checked, so a refused start never moves the state
  assign start_ok = start && converter_enable &&
                    source_valid_now(config_bits.global_channel_gate,
                                     config_bits.channel_select_field);
  assign bits_total = resolution_bits(held.resolution_sel);
  assign sample_end = tick && (period_count == sample_periods(held.sample_width_sel) - 4'h1);
  assign convert_end = tick && (bit_index == bits_total - 4'h1);
  assign tail_end = tick && (tail_count == 2'(`SAS_EXTRA_PERIODS - 5'h01));

  always_comb
  begin
    next_state = state;
    case (state)
      sas_pkg::SAS_IDLE:
        if (start_ok)
          next_state = sas_pkg::SAS_SAMPLE;
      sas_pkg::SAS_SAMPLE:
        if (sample_end)
          next_state = sas_pkg::SAS_CONVERT;
      sas_pkg::SAS_CONVERT:
        if (convert_end)
          next_state = sas_pkg::SAS_FINISH;
      sas_pkg::SAS_FINISH:
        if (tail_end)
          next_state = sas_pkg::SAS_IDLE;
      default:
        next_state = sas_pkg::SAS_IDLE;
    endcase
    // Dropping the enable aborts a conversion without raising done
    if (!converter_enable)
      next_state = sas_pkg::SAS_IDLE;
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state <= sas_pkg::SAS_IDLE;
    else if (clock_enable)
      state <= next_state;
  end

  // ==========================================================
  // Settings latch
  // ==========================================================
  // Settings are frozen for the whole conversion; a change mid-run waits
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      held <= '0;
    else if (clock_enable && state == sas_pkg::SAS_IDLE)
      held <= config_bits;
  end

  // ==========================================================
  // Sample phase
  // ==========================================================
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      period_count <= 4'h0;
    else if (clock_enable)
    begin
      if (state != sas_pkg::SAS_SAMPLE)
        period_count <= 4'h0;
      else if (tick)
        period_count <= period_count + 4'h1;
    end
  end

  // ==========================================================
  // Bit decisions
  // ==========================================================
  // One decision per conversion clock period, MSB first
  // The comparator answers in the strobe cycle, so each bit lands at that edge
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      bit_index <= 4'h0;
      sar <= `SAS_RESULT_RESET;
    end
    else if (clock_enable)
    begin
      if (state == sas_pkg::SAS_SAMPLE)
      begin
        bit_index <= 4'h0;
        sar <= `SAS_RESULT_RESET;
      end
      else if (state == sas_pkg::SAS_CONVERT && tick)
      begin
        bit_index <= bit_index + 4'h1;
        sar[4'd11 - bit_index] <= compare_high;
      end
    end
  end

  // ==========================================================
  // Finish phase
  // ==========================================================
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      tail_count <= 2'b00;
    else if (clock_enable)
    begin
      if (state != sas_pkg::SAS_FINISH)
        tail_count <= 2'b00;
      else if (tick)
        tail_count <= tail_count + 2'b01;
    end
  end

  // ==========================================================
  // Done and result
  // ==========================================================
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      done <= 1'b0;
      result <= `SAS_RESULT_RESET;
      done_prev <= 1'b0;
    end
    else if (clock_enable)
    begin
      done_prev <= done;
      if (start_ok && state == sas_pkg::SAS_IDLE)
        done <= 1'b0;
      else if (state == sas_pkg::SAS_FINISH && tail_end)
      begin
        done <= 1'b1;
        result <= sar;
      end
    end
  end

  // ==========================================================
  // Interrupt flag
  // ==========================================================
  // Only the rising edge sets the flag, so a done left high cannot re-raise it
  assign done_rise = done && !done_prev;

  // Set beats a same-cycle software clear so no completion is lost
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      irq_flag <= 1'b0;
    else if (clock_enable)
    begin
      if (done_rise)
        irq_flag <= 1'b1;
      else if (irq_flag_write_zero)
        irq_flag <= 1'b0;
    end
  end

  assign conv_irq_flag_read = irq_flag && conv_irq_enable;
  assign conv_irq_request = irq_flag && conv_irq_enable && global_irq_enable;
  assign busy = state != sas_pkg::SAS_IDLE;

  // ==========================================================
  // Analog side outputs
  // ==========================================================
  // One assignment drives the whole bundle, so the port has a single driver
  assign analog_ctrl = '{
    analog_sel_valid: busy && source_valid,
    analog_source: busy ? source_code : `SAS_SOURCE_NONE,
    sample_pulse_width: state == sas_pkg::SAS_SAMPLE,
    bit_strobe: state == sas_pkg::SAS_CONVERT && tick,
    bit_index: bit_index
  };

endmodule
`default_nettype wire

// ---- test/sas_comparator_model.sv ----
/*
  Behavioural model of the SAR comparator; analog_source and analog_sel_valid are ignored.
  Assumes the sequencer samples compare_high in its bit strobe cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module sas_comparator_model (
  input wire logic clock,
  input wire sas_pkg::sas_analog_t analog_ctrl,
  input wire logic [11:0] target,
  output logic compare_high
);
  logic churn = 1'b0;
  always @(posedge clock)
    churn <= !churn;
  // Off strobe the line churns, so a late sample cannot luck into the right bit
  assign compare_high = analog_ctrl.bit_strobe ? target[4'hB - analog_ctrl.bit_index] : churn;
endmodule
`default_nettype wire

// ---- test/sas_sequencer_assertions.sv ----
/*
  Concurrent checks on the sequencer ports.
  Assumes binding onto sas_sequencer, single clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module sas_sequencer_assertions (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire sas_pkg::sas_config_t config_bits,
  input wire logic converter_enable,
  input wire logic start,
  input wire logic conv_irq_enable,
  input wire logic global_irq_enable,
  input wire logic irq_flag_write_zero,
  input wire sas_pkg::sas_analog_t analog_ctrl,
  input wire logic [4:0] porta_analog_select,
  input wire logic busy,
  input wire logic done,
  input wire logic conv_irq_flag_read,
  input wire logic conv_irq_request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire logic take = clock_enable && !busy && start && converter_enable
    && config_bits.global_channel_gate && (config_bits.channel_select_field < 4'hE);
  // ====================
  // Checks
  a_gate_blocks:
    assert property (!busy && !config_bits.global_channel_gate |=> !busy) else $error("gate low but started");
  a_idle_source:
    assert property (!busy |-> analog_ctrl.analog_source == 4'hF) else $error("idle source not none");
  a_porta_decode:
    assert property (busy && analog_ctrl.analog_source <= 4'h4
      |-> porta_analog_select == (5'h01 << analog_ctrl.analog_source)) else $error("pin select wrong");
  a_start_taken:
    assert property (take |=> busy && !done) else $error("start not taken");
  a_done_low_busy:
    assert property (busy |-> !done) else $error("done high while busy");
  a_irq_and:
    assert property (conv_irq_request == (conv_irq_flag_read && global_irq_enable)) else $error("request gating wrong");
  a_read_needs_enable:
    assert property (!conv_irq_enable |-> !conv_irq_flag_read) else $error("flag readable while disabled");
  a_flag_on_done:
    assert property ($rose(done) ##1 conv_irq_enable |-> conv_irq_flag_read) else $error("flag not set at done");
  a_flag_sticky:
    assert property (conv_irq_flag_read && !irq_flag_write_zero ##1 conv_irq_enable
      |-> conv_irq_flag_read) else $error("flag dropped by itself");
  a_frozen_state:
    assert property (!clock_enable |=> $stable(done) && $stable(busy)) else $error("moved while frozen");
  c_done: cover property ($rose(done));
  c_request: cover property (conv_irq_request);
  c_abort: cover property ($fell(busy) && !done);
endmodule
bind sas_sequencer sas_sequencer_assertions i_chk (.clock(clock), .reset(reset),
  .clock_enable(clock_enable), .config_bits(config_bits), .converter_enable(converter_enable),
  .start(start), .conv_irq_enable(conv_irq_enable), .global_irq_enable(global_irq_enable),
  .irq_flag_write_zero(irq_flag_write_zero), .analog_ctrl(analog_ctrl),
  .porta_analog_select(porta_analog_select), .busy(busy), .done(done),
  .conv_irq_flag_read(conv_irq_flag_read), .conv_irq_request(conv_irq_request));
`default_nettype wire

// ---- test/tb_top.sv ----
/*
  Self-checking bench for the converter sequencer.
  Assumes the comparator model on the analog side.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sas_params.svh"
module tb_top;
  typedef struct {logic [1:0] dv, sw, rs; logic [3:0] ch; logic [11:0] tgt; int cyc;} sas_row_t;
  localparam int LIMIT = 70000;
  logic clock, reset, clock_enable, converter_enable, start, conv_irq_enable, global_irq_enable;
  logic irq_flag_write_zero, compare_high, busy, done, flag_read, irq_req;
  logic [4:0] pa_bits, pa_sel, pa_dig;
  logic [7:0] pb_bits, pb_dig;
  logic [7:1] pb_sel;
  logic [11:0] result, target;
  sas_pkg::sas_config_t config_bits;
  sas_pkg::sas_analog_t analog_ctrl;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  sas_row_t rows[7] = '{'{2'b00, 2'b11, 2'b10, 4'h0, 12'hA5A, 352},
    '{2'b01, 2'b10, 2'b01, 4'h5, 12'h3C7, 128}, '{2'b10, 2'b00, 2'b00, 4'hB, 12'hFFF, 11},
    '{2'b11, 2'b01, 2'b11, 4'hC, 12'h001, 32}, '{2'b10, 2'b01, 2'b01, 4'hD, 12'h800, 14},
    '{2'b11, 2'b11, 2'b00, 4'h4, 12'h5A5, 36}, '{2'b10, 2'b10, 2'b10, 4'h7, 12'h123, 18}};
  sas_sequencer i_dut (.clock(clock), .reset(reset), .clock_enable(clock_enable),
    .config_bits(config_bits), .converter_enable(converter_enable), .start(start),
    .conv_irq_enable(conv_irq_enable), .global_irq_enable(global_irq_enable),
    .irq_flag_write_zero(irq_flag_write_zero), .porta_analog_pin_bit(pa_bits),
    .portb_analog_pin_bit(pb_bits), .compare_high(compare_high), .analog_ctrl(analog_ctrl),
    .porta_analog_select(pa_sel), .portb_analog_select(pb_sel), .porta_digital_enable(pa_dig),
    .portb_digital_enable(pb_dig), .busy(busy), .done(done), .result(result),
    .conv_irq_flag_read(flag_read), .conv_irq_request(irq_req));
  sas_comparator_model i_cmp (.clock(clock), .analog_ctrl(analog_ctrl), .target(target),
    .compare_high(compare_high));
  // ====================
  // Helpers
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check_flag(string what, logic exp, logic got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_vec(string what, logic [11:0] exp, logic [11:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_int(string what, int exp, int got);
    cmp_count++;
    if (got != exp)
    begin
      miscompares++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic clear_flag();
    irq_flag_write_zero = 1'b1;
    step(1);
    irq_flag_write_zero = 1'b0;
    check_flag("flag clear", 1'b0, flag_read);
  endtask
  task automatic run_conv(logic [1:0] dv, sw, rs, logic [3:0] ch, int cyc);
    int d, n, pulse, strobes, k;
    logic [11:0] mask;
    d = (dv == 2'b00) ? 16 : (dv == 2'b01) ? 8 : (dv == 2'b10) ? 1 : 2;
    n = rs[1] ? 12 : rs[0] ? 10 : 8;
    mask = rs[1] ? 12'hFFF : rs[0] ? 12'hFFC : 12'hFF0;
    config_bits = '{dv, sw, rs, 1'b1, ch};
    start = 1'b1;
    step(1);
    start = 1'b0;
    pulse = 0;
    strobes = 0;
    k = 0;
    check_flag("busy", 1'b1, busy);
    check_flag("done low", 1'b0, done);
    check_vec("source", {8'h00, ch}, {8'h00, analog_ctrl.analog_source});
    check_flag("sel valid", 1'b1, analog_ctrl.analog_sel_valid);
    check_vec("pins", (ch <= 4'h4) ? 12'h001 << ch : (ch <= 4'hB) ? 12'h020 << (ch - 4'h5)
      : 12'h000, {pb_sel, pa_sel});
    check_vec("dig a", {7'h00, ~pa_bits}, {7'h00, pa_dig});
    check_vec("dig b", {4'h0, ~pb_bits}, {4'h0, pb_dig});
    while (done !== 1'b1 && k < 400)
    begin
      pulse += analog_ctrl.sample_pulse_width;
      strobes += analog_ctrl.bit_strobe;
      step(1);
      k++;
    end
    check_int("cycles", cyc, k);
    check_int("sample", (1 << sw) * d, pulse);
    check_int("strobes", n, strobes);
    check_vec("result", target & mask, result);
    step(1);
    check_flag("request", conv_irq_enable & global_irq_enable, irq_req);
  endtask
  // ====================
  // Stimulus
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      complete_run();
    end
  end
  initial
  begin
    {clock_enable, converter_enable, start, irq_flag_write_zero} = 4'h8;
    {conv_irq_enable, global_irq_enable} = 2'h3;
    // Analog pins are plain inputs with no pulls on the far side
    {pa_bits, pb_bits, target} = {5'h15, 8'hA6, 12'h000};
    config_bits = '0;
    reset = 1'b1;
    step(16);
    check_flag("done reset", 1'b0, done);
    check_vec("result reset", 12'h000, result);
    check_flag("flag reset", 1'b0, flag_read);
    check_vec("source reset", 12'h00F, {8'h00, analog_ctrl.analog_source});
    reset = 1'b0;
    converter_enable = 1'b1;
    step(`SAS_BIAS_CYCLES);
    $display("test reset finished");
    foreach (rows[i])
    begin
      target = rows[i].tgt;
      {pa_bits, pb_bits} = ~{pa_bits, pb_bits};
      run_conv(rows[i].dv, rows[i].sw, rows[i].rs, rows[i].ch, rows[i].cyc);
      clear_flag();
    end
    $display("test rows finished");
    config_bits.global_channel_gate = 1'b0;
    start = 1'b1;
    step(3);
    check_flag("busy no gate", 1'b0, busy);
    config_bits = '{2'b10, 2'b00, 2'b00, 1'b1, 4'hE};
    step(2);
    check_flag("busy code e", 1'b0, busy);
    config_bits.channel_select_field = 4'hF;
    step(2);
    check_flag("busy code f", 1'b0, busy);
    config_bits.channel_select_field = 4'h1;
    clock_enable = 1'b0;
    step(3);
    check_flag("busy frozen", 1'b0, busy);
    check_flag("done held", 1'b1, done);
    {clock_enable, start} = 2'b10;
    $display("test refusals finished");
    conv_irq_enable = 1'b0;
    run_conv(2'b10, 2'b00, 2'b00, 4'h2, 11);
    check_flag("read masked", 1'b0, flag_read);
    conv_irq_enable = 1'b1;
    global_irq_enable = 1'b0;
    step(1);
    check_flag("read kept", 1'b1, flag_read);
    check_flag("request gie", 1'b0, irq_req);
    global_irq_enable = 1'b1;
    step(1);
    check_flag("request on", 1'b1, irq_req);
    clear_flag();
    $display("test interrupt finished");
    start = 1'b1;
    step(1);
    start = 1'b0;
    step(5);
    reset = 1'b1;
    converter_enable = 1'b0;
    config_bits.conv_clock_divider_sel = 2'b00;
    step(1);
    check_flag("busy mid reset", 1'b0, busy);
    check_vec("result mid reset", 12'h000, result);
    check_flag("sel mid reset", 1'b0, analog_ctrl.analog_sel_valid);
    reset = 1'b0;
    converter_enable = 1'b1;
    step(`SAS_BIAS_CYCLES);
    start = 1'b1;
    step(1);
    start = 1'b0;
    step(20);
    converter_enable = 1'b0;
    step(2);
    check_flag("busy abort", 1'b0, busy);
    check_flag("done abort", 1'b0, done);
    check_flag("sel abort", 1'b0, analog_ctrl.analog_sel_valid);
    $display("test abort finished");
    complete_run();
  end
endmodule
`default_nettype wire
